// >>> sim/pram_arbiter_mmu_checker.sv
// Port-level checks for the packet RAM arbiter
`timescale 1ns/100ps
module pram_arbiter_mmu_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ptrWrite,
   input wire logic [10:0] ptrValue,
   input wire logic hostRd,
   input wire logic hostWord,
   input wire logic hostReady,
   input wire logic [10:0] ptrReadback,
   input wire logic engReq,
   input wire logic engAck,
   input wire logic hostAllocReq,
   input wire logic hostReleaseReq,
   input wire logic engAllocReq,
   input wire logic [7:0] txReservePages,
   input wire logic allocationDoneFlag,
   input wire logic allocFailed,
   input wire logic engAllocDone,
   input wire logic engAllocOk,
   input wire logic releaseBusy,
   input wire logic [7:0] freePages
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_ptr_load: assert property (ptrWrite |=> ptrReadback == $past(ptrValue))
      else $error("pointer load not taken");
   a_ofs_step: assert property (hostRd && hostReady && !ptrWrite |=>
      ptrReadback == $past(ptrReadback) + ($past(hostWord) ? 11'h002 : 11'h001)) else $error("offset step wrong");
   a_eng_wait: assert property (engReq && !engAck |-> ##[1:3] engAck)
      else $error("engine waited too long");
   a_ack_pulse: assert property (engAck |=> !engAck) else $error("engine ack too long");
   a_ack_cause: assert property (engAck |-> $past(engReq)) else $error("ack without request");
   a_alloc_done: assert property (hostAllocReq && !releaseBusy |->
      ##[1:3] (allocationDoneFlag || allocFailed)) else $error("allocation never completed");
   a_busy_set: assert property (hostReleaseReq |=> releaseBusy) else $error("release not busy");
   a_busy_end: assert property ($rose(releaseBusy) |-> ##[1:3] !releaseBusy)
      else $error("release busy stuck");
   a_rx_reserve: assert property (engAllocReq && !releaseBusy && freePages < txReservePages |->
      ##[1:3] (engAllocDone && !engAllocOk)) else $error("receive allocation below reserve");
   a_free_max: assert property (freePages <= 8'h10) else $error("free count too high");
   cover property (engReq && !engAck ##1 engAck);
   cover property (hostRd && hostReady && hostWord);
   cover property ($fell(releaseBusy));
endmodule : pram_arbiter_mmu_checker

// >>> sim/pram_engine_model.sv
// Engine-side memory requester model
`timescale 1ns/100ps
module pram_engine_model (
   input wire logic ref_clk,
   output logic engReq,
   output logic engWr,
   output logic [3:0] engPkt,
   output logic [10:0] engAddr,
   output logic [7:0] engWdata,
   input wire logic [7:0] engRdata,
   input wire logic engAck
);
   initial begin
      engReq = 1'b0;
      engWr = 1'b0;
      engPkt = 4'h0;
      engAddr = 11'h000;
      engWdata = 8'h00;
   end
   task automatic access(input logic wr, input logic [3:0] pkt, input logic [10:0] adr,
      input logic [7:0] wd, input int stall, output logic [7:0] rd);
      int n;
      repeat (stall + 1) @(negedge ref_clk);
      engReq = 1'b1;
      engWr = wr;
      engPkt = pkt;
      engAddr = adr;
      engWdata = wd;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (engAck !== 1'b1 && n < 20);
      rd = engRdata;
      @(negedge ref_clk);
      engReq = 1'b0;
      // Released lines show junk, not the last value
      engAddr = ~adr;
      engWdata = ~wd;
   endtask : access
endmodule : pram_engine_model

// >>> sim/tb.sv
// Self-checking bench for the packet RAM arbiter
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] currentPacketSelect = 4'h0;
   logic ptrWrite = 1'b0;
   logic [10:0] ptrValue = 11'h000;
   logic hostWr = 1'b0;
   logic hostRd = 1'b0;
   logic hostWord = 1'b0;
   logic [15:0] hostWdata = 16'h0000;
   logic hostAllocReq = 1'b0;
   logic hostReleaseReq = 1'b0;
   logic [3:0] hostReleasePkt = 4'h0;
   logic engAllocReq = 1'b0;
   logic engReleaseReq = 1'b0;
   logic [3:0] engReleasePkt = 4'h0;
   logic [7:0] txReservePages = 8'h00;
   logic [15:0] hostRdata;
   logic hostReady, engReq, engWr, engAck, allocationDoneFlag, allocFailed, engAllocDone, engAllocOk, releaseBusy;
   logic [10:0] ptrReadback, engAddr;
   logic [3:0] engPkt, allocResult;
   logic [7:0] engWdata, engRdata, freePages, rd2;
   logic [15:0] rd;
   logic [10:0] saved;
   logic [15:0] used;
   logic bad;
   int failCount = 0;
   int nCompared = 0;
   always #20 ref_clk = ~ref_clk;
   pram_arbiter_mmu dut (.ref_clk, .rst_n, .currentPacketSelect, .ptrWrite, .ptrValue, .hostWr, .hostRd,
      .hostWord, .hostWdata, .hostRdata, .hostReady, .ptrReadback, .engReq, .engWr, .engPkt, .engAddr,
      .engWdata, .engRdata, .engAck, .hostAllocReq, .hostReleaseReq, .hostReleasePkt, .engAllocReq,
      .engReleaseReq, .engReleasePkt, .txReservePages, .allocationDoneFlag, .allocFailed, .allocResult,
      .engAllocDone, .engAllocOk, .releaseBusy, .freePages);
   pram_engine_model eng (.ref_clk, .engReq, .engWr, .engPkt, .engAddr, .engWdata, .engRdata, .engAck);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic completeRun;
      if (failCount == 0 && nCompared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : completeRun
   task automatic setPtr(input logic [3:0] pkt, input logic [10:0] ofs);
      // Let write-behind drain before the prefetch
      repeat (20) @(negedge ref_clk);
      currentPacketSelect = pkt;
      ptrValue = ofs;
      ptrWrite = 1'b1;
      @(negedge ref_clk);
      ptrWrite = 1'b0;
   endtask : setPtr
   task automatic host(input logic wr, input logic word, input logic [15:0] wd, output logic [15:0] rv);
      int n;
      n = 0;
      @(negedge ref_clk);
      hostWord = word;
      hostWdata = wd;
      hostWr = wr;
      hostRd = !wr;
      // Strobe stands until ready is seen at a rising edge
      @(posedge ref_clk);
      while (hostReady !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      chk(16'(hostReady), 16'h0001, "host ready");
      @(negedge ref_clk);
      hostWr = 1'b0;
      hostRd = 1'b0;
      if (word && !wr) begin
         @(negedge ref_clk);
      end
      rv = hostRdata;
   endtask : host
   task automatic alloc(output logic [3:0] num, output logic fl);
      int n;
      n = 0;
      @(negedge ref_clk);
      hostAllocReq = 1'b1;
      @(negedge ref_clk);
      hostAllocReq = 1'b0;
      while (allocationDoneFlag !== 1'b1 && allocFailed !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      num = allocResult;
      fl = allocFailed;
   endtask : alloc
   task automatic freePkt(input logic [3:0] num);
      hostReleasePkt = num;
      hostReleaseReq = 1'b1;
      @(negedge ref_clk);
      hostReleaseReq = 1'b0;
      chk(16'(releaseBusy), 16'h0001, "busy");
      repeat (4) @(negedge ref_clk);
      chk(16'(releaseBusy), 16'h0000, "busy end");
   endtask : freePkt
   task automatic engAlloc(output logic ok);
      int n;
      n = 0;
      engAllocReq = 1'b1;
      @(negedge ref_clk);
      engAllocReq = 1'b0;
      while (engAllocDone !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      ok = engAllocOk;
      @(negedge ref_clk);
   endtask : engAlloc
   task automatic testHostPath;
      setPtr(4'h3, 11'h005);
      host(1'b1, 1'b0, 16'h00A1, rd);
      host(1'b1, 1'b0, 16'h00B2, rd);
      host(1'b1, 1'b0, 16'h00C3, rd);
      host(1'b1, 1'b1, 16'hE5D4, rd);
      setPtr(4'h3, 11'h005);
      host(1'b0, 1'b0, 16'h0000, rd);
      chk(16'(rd), 16'h00A1, "read 0");
      host(1'b0, 1'b0, 16'h0000, rd);
      chk(16'(rd), 16'h00B2, "read 1");
      host(1'b0, 1'b0, 16'h0000, rd);
      chk(16'(rd), 16'h00C3, "read 2");
      chk(16'(ptrReadback), 16'h0008, "offset");
      setPtr(4'h3, 11'h005);
      host(1'b0, 1'b1, 16'h0000, rd);
      chk(16'(rd), 16'hB2A1, "odd word");
      chk(16'(ptrReadback), 16'h0007, "word offset");
      saved = ptrReadback;
      setPtr(4'h9, 11'h000);
      setPtr(4'h3, saved);
      host(1'b0, 1'b0, 16'h0000, rd);
      chk(16'(rd), 16'h00C3, "after word");
      host(1'b0, 1'b1, 16'h0000, rd);
      chk(16'(rd), 16'hE5D4, "word write");
   endtask : testHostPath
   task automatic testEngine;
      eng.access(1'b1, 4'h9, 11'h010, 8'h5A, 0, rd2);
      setPtr(4'h9, 11'h010);
      fork
         eng.access(1'b0, 4'h3, 11'h006, 8'h00, 2, rd2);
         host(1'b0, 1'b0, 16'h0000, rd);
      join
      chk(16'(rd), 16'h005A, "engine to host");
      chk(16'(rd2), 16'h00B2, "host to engine");
   endtask : testEngine
   task automatic testAlloc;
      logic [3:0] num;
      used = 16'h0000;
      repeat (16) begin
         alloc(num, bad);
         chk(16'(bad), 16'h0000, "alloc ok");
         chk(16'(used[num]), 16'h0000, "unique number");
         used[num] = 1'b1;
      end
      chk(16'(freePages), 16'h0000, "pool empty");
      alloc(num, bad);
      chk(16'(bad), 16'h0001, "alloc refused");
      // freed numbers sit in no queue
      freePkt(4'h5);
      alloc(num, bad);
      chk(16'(num), 16'h0005, "reuse after free");
   endtask : testAlloc
   task automatic testReserve;
      freePkt(4'h1);
      freePkt(4'h2);
      txReservePages = 8'h04;
      engAlloc(bad);
      chk(16'(bad), 16'h0000, "below reserve");
      txReservePages = 8'h00;
      engAlloc(bad);
      chk(16'(bad), 16'h0001, "no reserve");
   endtask : testReserve
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      testHostPath();
      testEngine();
      testAlloc();
      testReserve();
      completeRun();
   end
   initial begin
      #400000;
      failCount++;
      completeRun();
   end
endmodule : tb
bind pram_arbiter_mmu pram_arbiter_mmu_checker chk_i (.ref_clk, .rst_n, .ptrWrite, .ptrValue, .hostRd, .hostWord,
   .hostReady, .ptrReadback, .engReq, .engAck, .hostAllocReq, .hostReleaseReq, .engAllocReq, .txReservePages,
   .allocationDoneFlag, .allocFailed, .engAllocDone, .engAllocOk, .releaseBusy, .freePages);

// >>> src/pram_arbiter_mmu.sv
// Packet RAM arbiter with allocator and host data register buffers
`timescale 1ns/100ps
`include "pram_regs.svh"
module pram_arbiter_mmu
   import pram_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] currentPacketSelect,
   input wire logic ptrWrite,
   input wire logic [10:0] ptrValue,
   input wire logic hostWr,
   input wire logic hostRd,
   input wire logic hostWord,
   input wire logic [15:0] hostWdata,
   output logic [15:0] hostRdata,
   output logic hostReady,
   output logic [10:0] ptrReadback,
   input wire logic engReq,
   input wire logic engWr,
   input wire logic [3:0] engPkt,
   input wire logic [10:0] engAddr,
   input wire logic [7:0] engWdata,
   output logic [7:0] engRdata,
   output logic engAck,
   input wire logic hostAllocReq,
   input wire logic hostReleaseReq,
   input wire logic [3:0] hostReleasePkt,
   input wire logic engAllocReq,
   input wire logic engReleaseReq,
   input wire logic [3:0] engReleasePkt,
   input wire logic [7:0] txReservePages,
   output logic allocationDoneFlag,
   output logic allocFailed,
   output logic [3:0] allocResult,
   output logic engAllocDone,
   output logic engAllocOk,
   output logic releaseBusy,
   output logic [7:0] freePages
);
   // Static page map: each number owns one 256-byte region of 16 slots
   logic [`PRAM_PKT_N-1:0] inUse, next_inUse;
   logic [7:0] ram [4096];
   pram_owner_t owner, next_owner;
   logic [10:0] seqOfs, next_seqOfs;
   logic [2:0] relCnt, next_relCnt;
   logic [3:0] relPkt, next_relPkt;
   logic hostPend, next_hostPend;
   logic allocDone, next_allocDone, allocFail, next_allocFail;
   logic [3:0] allocNum, next_allocNum;
   logic engDone, next_engDone, engOk, next_engOk;
   logic [15:0] rdOut, next_rdOut;
   logic [7:0] engOut, next_engOut;
   logic engAckR, next_engAckR, lastHost, next_lastHost;
   logic hostAllocPend, next_hostAllocPend;
   logic wfInValid, wfInReady, wfOutValid, wfOutReady;
   pram_wbyte_t wfIn, wfOut;
   logic [4:0] wfCount, rfCount;
   logic rfInValid, rfInReady, rfOutValid, rfOutReady, rfFlush;
   logic [7:0] rfIn, rfOut;
   logic [3:0] freeIdx;
   logic freeAny;
   logic [4:0] usedCount;
   pram_addr_t hostAddr, engAddrS;
   logic hostMemReq, hostIsWrite, doHost, doEng;
   logic [11:0] physAddr;
   logic [7:0] ramWbyte;
   // Word halves and read-ahead position
   logic [10:0] fetchOfs, next_fetchOfs;
   logic rdHiPend, next_rdHiPend;
   logic wrHiPend, next_wrHiPend;
   logic [7:0] wrHiData, next_wrHiData;
   logic [10:0] wrHiOfs, next_wrHiOfs;
   logic hostTake;
   logic rdRoom, wrRoom;

   // Offsets beyond one page wrap back into it
   // Map by packet and offset
   function automatic logic [11:0] pram_map(input pram_addr_t a);
      pram_map = {a.pkt, a.ofs[7:0]};
   endfunction : pram_map

   always_comb begin
      freeIdx = '0;
      freeAny = 1'b0;
      usedCount = '0;
      for (int i = `PRAM_PKT_N - 1; i >= 0; i--) begin
         if (!inUse[i]) begin
            freeIdx = 4'(i);
            freeAny = 1'b1;
         end
      end
      for (int i = 0; i < `PRAM_PKT_N; i++) usedCount = usedCount + 5'(inUse[i]);
   end
   // One page per number, so free pages equal free numbers
   assign freePages = 8'(5'(`PRAM_PKT_N) - usedCount);

   assign hostAddr = '{pkt: currentPacketSelect, ofs: hostIsWrite ? wfOut.ofs : fetchOfs};
   assign engAddrS = '{pkt: engPkt, ofs: engAddr};
   pram_fifo #(.WIDTH(19), .DEPTH(`PRAM_FIFO_DEPTH), .AW(`PRAM_FIFO_AW)) uWrFifo (
      .ref_clk(ref_clk), .rst_n(rst_n), .flush(1'b0),
      .inValid(wfInValid), .inReady(wfInReady), .inData(wfIn),
      .outValid(wfOutValid), .outReady(wfOutReady), .outData(wfOut), .count(wfCount));
   pram_fifo #(.WIDTH(8), .DEPTH(`PRAM_FIFO_DEPTH), .AW(`PRAM_FIFO_AW)) uRdFifo (
      .ref_clk(ref_clk), .rst_n(rst_n), .flush(rfFlush),
      .inValid(rfInValid), .inReady(rfInReady), .inData(rfIn),
      .outValid(rfOutValid), .outReady(rfOutReady), .outData(rfOut), .count(rfCount));

   // Word needs two bytes of room or data
   // Second byte of a word moves a cycle later, so one FIFO port suffices
   assign wrRoom = (wfCount <= 5'd14) && !wrHiPend;
   assign rdRoom = (rfCount >= (hostWord ? 5'd2 : 5'd1)) && !rdHiPend;
   always_comb begin
      if (hostWr) begin
         hostReady = wrRoom;
      end else if (hostRd) begin
         hostReady = rdRoom;
      end else begin
         hostReady = 1'b1;
      end
   end
   // Pointer load wins over a data access in the same cycle
   assign hostTake = hostReady && (hostRd || hostWr) && !ptrWrite;
   assign wfInValid = (hostWr && hostTake) || wrHiPend;
   always_comb begin
      if (wrHiPend) begin
         wfIn = '{ofs: wrHiOfs, data: wrHiData};
      end else begin
         wfIn = '{ofs: seqOfs, data: hostWdata[7:0]};
      end
   end
   assign rfOutReady = (hostRd && hostTake) || rdHiPend;
   assign rfFlush = ptrWrite;

   // Writes drain before prefetch so reads see fresh data
   assign hostIsWrite = wfOutValid;
   assign hostMemReq = wfOutValid || (hostPend && rfInReady);
   // Engine served next after any host cycle
   always_comb begin
      doEng = 1'b0;
      doHost = 1'b0;
      if (engReq && !engAckR && (lastHost || !hostMemReq)) doEng = 1'b1;
      else if (hostMemReq) doHost = 1'b1;
   end
   assign physAddr = doEng ? pram_map(engAddrS) : pram_map(hostAddr);
   assign ramWbyte = doEng ? engWdata : wfOut.data;
   assign wfOutReady = doHost && hostIsWrite;
   assign rfInValid = doHost && !hostIsWrite && !ptrWrite;
   assign rfIn = ram[pram_map(hostAddr)];
   assign hostRdata = rdOut;
   assign engRdata = engOut;
   assign engAck = engAckR;
   assign ptrReadback = seqOfs;
   assign allocationDoneFlag = allocDone;
   assign allocFailed = allocFail;
   assign allocResult = allocNum;
   assign engAllocDone = engDone;
   assign engAllocOk = engOk;
   assign releaseBusy = (relCnt != '0);

   always_ff @(posedge ref_clk) begin
      if ((doEng && engWr) || (doHost && hostIsWrite)) ram[physAddr] <= ramWbyte;
   end

   always_comb begin
      next_owner = doEng ? PRAM_ENG : doHost ? PRAM_HOST : PRAM_IDLE;
      next_lastHost = doHost ? 1'b1 : doEng ? 1'b0 : lastHost;
      next_engAckR = doEng;
      next_engOut = doEng ? ram[physAddr] : engOut;
      next_seqOfs = seqOfs;
      next_hostPend = hostPend;
      next_rdOut = rdOut;
      next_inUse = inUse;
      next_relCnt = relCnt;
      next_relPkt = relPkt;
      next_allocDone = allocDone;
      next_allocFail = allocFail;
      next_allocNum = allocNum;
      next_engDone = 1'b0;
      next_engOk = engOk;
      next_hostAllocPend = hostAllocPend;
      next_fetchOfs = fetchOfs;
      next_rdHiPend = 1'b0;
      next_wrHiPend = 1'b0;
      next_wrHiData = wrHiData;
      next_wrHiOfs = wrHiOfs;
      if (ptrWrite) begin
         next_seqOfs = ptrValue;
         next_fetchOfs = ptrValue;
         next_hostPend = 1'b1;
      end else if (hostTake) begin
         next_seqOfs = seqOfs + (hostWord ? 11'd2 : 11'd1);
         next_hostPend = hostRd ? 1'b1 : hostPend;
         if (hostRd) begin
            next_rdOut = {8'h00, rfOut};
            next_rdHiPend = hostWord;
         end else begin
            next_wrHiPend = hostWord;
            next_wrHiData = hostWdata[15:8];
            next_wrHiOfs = seqOfs + 11'd1;
         end
      end
      // Read-ahead walks its own offset, ahead of the host
      if (rfInValid && rfInReady) begin
         next_fetchOfs = fetchOfs + 11'd1;
      end
      // High byte of a word read
      if (rdHiPend) begin
         next_rdOut = {rfOut, rdOut[7:0]};
      end
      // Release: count down, then free the number
      if (relCnt != '0) begin
         next_relCnt = relCnt - 3'd1;
         if (relCnt == 3'd1) next_inUse[relPkt] = 1'b0;
      end else if (hostReleaseReq || engReleaseReq) begin
         next_relCnt = 3'(`PRAM_RELEASE_CYC);
         next_relPkt = hostReleaseReq ? hostReleasePkt : engReleasePkt;
      end else if (engAllocReq) begin
         next_engDone = 1'b1;
         if (freeAny && (freePages > txReservePages)) begin
            next_inUse[freeIdx] = 1'b1;
            next_engOk = 1'b1;
         end else next_engOk = 1'b0;
      end else if (hostAllocPend || hostAllocReq) begin
         next_hostAllocPend = 1'b0;
         next_allocDone = 1'b1;
         next_allocFail = !freeAny;
         if (freeAny) begin
            next_inUse[freeIdx] = 1'b1;
            next_allocNum = freeIdx;
         end
      end
      if (hostAllocReq) begin
         next_allocDone = 1'b0;
         next_hostAllocPend = (relCnt != '0) || hostReleaseReq || engReleaseReq || engAllocReq;
         if (!next_hostAllocPend) next_allocDone = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         owner <= PRAM_IDLE;
         lastHost <= 1'b0;
         engAckR <= 1'b0;
         engOut <= 8'h00;
         seqOfs <= 11'h000;
         hostPend <= 1'b0;
         rdOut <= 16'h0000;
         inUse <= 16'h0000;
         relCnt <= 3'h0;
         relPkt <= 4'h0;
         allocDone <= 1'b0;
         allocFail <= 1'b0;
         allocNum <= 4'h0;
         engDone <= 1'b0;
         engOk <= 1'b0;
         hostAllocPend <= 1'b0;
         fetchOfs <= 11'h000;
         rdHiPend <= 1'b0;
         wrHiPend <= 1'b0;
         wrHiData <= 8'h00;
         wrHiOfs <= 11'h000;
      end else begin
         owner <= next_owner;
         lastHost <= next_lastHost;
         engAckR <= next_engAckR;
         engOut <= next_engOut;
         seqOfs <= next_seqOfs;
         hostPend <= next_hostPend;
         rdOut <= next_rdOut;
         inUse <= next_inUse;
         relCnt <= next_relCnt;
         relPkt <= next_relPkt;
         allocDone <= next_allocDone;
         allocFail <= next_allocFail;
         allocNum <= next_allocNum;
         engDone <= next_engDone;
         engOk <= next_engOk;
         hostAllocPend <= next_hostAllocPend;
         fetchOfs <= next_fetchOfs;
         rdHiPend <= next_rdHiPend;
         wrHiPend <= next_wrHiPend;
         wrHiData <= next_wrHiData;
         wrHiOfs <= next_wrHiOfs;
      end
   end
endmodule : pram_arbiter_mmu

// >>> src/pram_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module pram_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [AW:0] count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rdPtr, wrPtr, next_rdPtr, next_wrPtr;
   logic [AW:0] next_count;
   logic push, pop;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   always_comb begin
      next_rdPtr = rdPtr;
      next_wrPtr = wrPtr;
      next_count = count;
      if (flush) begin
         next_rdPtr = '0;
         next_wrPtr = '0;
         next_count = '0;
      end else begin
         if (push) next_wrPtr = wrPtr + 1'b1;
         if (pop) next_rdPtr = rdPtr + 1'b1;
         next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPtr <= '0;
         wrPtr <= '0;
         count <= '0;
      end else begin
         rdPtr <= next_rdPtr;
         wrPtr <= next_wrPtr;
         count <= next_count;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (push && !flush) mem[wrPtr] <= inData;
   end
endmodule : pram_fifo

// >>> src/pram_pkg.sv
// Types for the packet RAM arbiter and memory manager
package pram_pkg;
   typedef struct packed {
      logic [3:0] pkt;
      logic [10:0] ofs;
   } pram_addr_t;
   typedef struct packed {
      logic [10:0] ofs;
      logic [7:0] data;
   } pram_wbyte_t;
   typedef enum logic [2:0] {
      PRAM_IDLE = 3'b001,
      PRAM_HOST = 3'b010,
      PRAM_ENG = 3'b100
   } pram_owner_t;
endpackage : pram_pkg

// >>> src/pram_regs.svh
// Constants for the packet RAM arbiter and memory manager
//
// Behaviour
// - Physical address from packet number and offset only
// - Every RAM and allocator request passes arbiter
// - Allocator takes requests from arbiter alone
// - Allocation request clears done flag at once; here cleared only while the request must wait, else set with the result
// - Busy shown while release executes
// - Allocator issues numbers; reuse only after release
// - Number queues hold every allocatable number; here a 16-bit inUse bitmap, no queues
// - Exactly two parties: host and engine
// - No address restriction for either requester
// - Host write completes once data is buffered
// - Host read served from buffer, triggers prefetch
// - Pointer write triggers prefetch of addressed data
// - Engine waits at most one memory cycle
// - Host uses pointer, engine uses DMA address
// - RAM data bypasses the allocator
// - Small FIFO each direction beside data register
// - Byte and word mix, odd pointers allowed
// - Receive allocation fails below transmit reserve
`ifndef PRAM_REGS_SVH
`define PRAM_REGS_SVH
`define PRAM_PKT_W 4
`define PRAM_PKT_N 16
`define PRAM_OFS_W 11
`define PRAM_PAGE_W 8
`define PRAM_RAM_AW 12
`define PRAM_FIFO_DEPTH 16
`define PRAM_FIFO_AW 4
`define PRAM_RELEASE_CYC 2
`endif
